//--- core/uart_rx_data_error_status.v
// Receive data path, per-character error flags and sticky receive status behind APB.
// Summary of operation
// - Data bits 7:0 read the received character and a write queues a character to transmit.
// - A stop bit not sampled high marks a framing error in data bit 8 and status bit 0.
// - With the FIFO on, each character keeps its own flags and the head's flags are shown.
// - Parity not matching the mode chosen by config bits 2 and 7 sets data bit 9 and status bit 1.
// - A line low at every sample of a frame, stop bit included, sets break in data bit 10 and status bit 2.
// - One break pushes exactly one all-zero character however long it lasts.
// - After a break no character is taken until the line goes idle high and a new start comes.
// - A character that completes while the FIFO is full sets overrun and leaves the FIFO intact.
// - Overrun in the data register drops once the FIFO has room again.
// - Any write to the error-clear location clears all four sticky status bits.
// - The error-clear location is write-only and shares offset 0x04 with the read-only status.
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`include "uart_rx_defs.vh"
module uart_rx_data_error_status #(
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = `FIFO_AW
) (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        rxLine,
    output reg  [7:0]  txChar,
    output reg         txCharValid,
    output wire        irq
);
    localparam RX_IDLE  = 3'h0;
    localparam RX_START = 3'h1;
    localparam RX_DATA  = 3'h2;
    localparam RX_PAR   = 3'h3;
    localparam RX_STOP  = 3'h4;
    localparam RX_BRK   = 3'h5;

    // Flags {break, parity, framing} stored beside each character; overrun is kept apart.
    function parityOf;
        input [7:0] d;
        begin
            parityOf = ^d;
        end
    endfunction

    wire apbWr = psel & penable & pwrite;
    wire apbRd = psel & penable & ~pwrite;
    reg  mapped;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    reg [7:0]  lineCfg_q;
    reg        fifoEn_q;
    reg [15:0] baudDiv_q;
    reg [3:0]  status_q;
    reg [4:0]  irqStat_q;
    reg [4:0]  irqMask_q;
    reg        ovrLive_q;

    reg [2:0]  state_q;
    reg [15:0] tick_q;
    reg [3:0]  phase_q;
    reg [3:0]  bitCnt_q;
    reg [7:0]  shift_q;
    reg        parOk_q;
    reg [7:0]  lowBits_q;

    reg [AW:0]   count_q;
    reg [AW-1:0] wrPtr_q;
    reg [AW-1:0] rdPtr_q;
    wire [10:0]  headData;

    wire full  = fifoEn_q ? (count_q == DEPTH[AW:0]) : (count_q != {(AW+1){1'b0}});
    wire empty = (count_q == {(AW+1){1'b0}});

    // A divisor of one turns every clock into a tick, the fastest rate the sampler supports.
    wire tickEnd = (tick_q >= baudDiv_q - 16'h0001);
    wire midSample = tickEnd && (phase_q == 4'h7);
    wire parEn = lineCfg_q[`CFG_PAR_EN];

    // Frame bits: start, eight data, optional parity, stop.
    wire [7:0] frameBits = parEn ? 8'h0b : 8'h0a;

    reg        push;
    reg [10:0] pushData;
    // Reading an empty port must not move the pointers, or the count would wrap.
    wire popRd = apbRd && (paddr == `DATA_PORT_OFS) && !empty;
    // The memory is addressed one entry ahead on a pop so the next head is ready a cycle later.
    wire [AW-1:0] rdAddrNext = (popRd && fifoEn_q) ? rdPtr_q + 1'b1 : rdPtr_q;

    rx_fifo_mem #(.WIDTH(11), .AW(AW)) u_mem (
        .clk_sys (clk_sys),
        .wrEn    (push),
        .wrAddr  (wrPtr_q),
        .wrData  (pushData),
        .rdAddr  (rdAddrNext),
        .rdData  (headData)
    );

    reg expPar;
    always @* begin
        if (lineCfg_q[`CFG_STICK]) begin
            expPar = ~lineCfg_q[`CFG_PAR_EVEN];
        end else begin
            expPar = parityOf(shift_q) ^ ~lineCfg_q[`CFG_PAR_EVEN];
        end
    end

    reg [2:0]  state_d;
    reg        charDone;
    reg        fErr;
    reg        brkDet;
    always @* begin
        state_d  = state_q;
        charDone = 1'b0;
        fErr     = 1'b0;
        brkDet   = 1'b0;
        case (state_q)
            RX_IDLE: begin
                if (!rxLine) begin
                    state_d = RX_START;
                end
            end
            RX_START: begin
                // A start bit that is high again at mid-bit was a glitch, not a frame.
                if (midSample) begin
                    state_d = rxLine ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                // The eighth data sample ends the field; a ninth would swallow the next bit.
                if (midSample && bitCnt_q == 4'h7) begin
                    state_d = parEn ? RX_PAR : RX_STOP;
                end
            end
            RX_PAR: begin
                if (midSample) begin
                    state_d = RX_STOP;
                end
            end
            RX_STOP: begin
                if (midSample) begin
                    if (!rxLine && lowBits_q >= frameBits - 8'h01) begin
                        brkDet  = 1'b1;
                        state_d = RX_BRK;
                    end else begin
                        fErr     = ~rxLine;
                        charDone = 1'b1;
                        state_d  = RX_IDLE;
                    end
                end
            end
            RX_BRK: begin
                if (rxLine) begin
                    state_d = RX_IDLE;
                end
            end
            default: state_d = RX_IDLE;
        endcase
    end

    wire pErr = parEn & ~parOk_q;
    wire anyEvt = charDone | brkDet;
    wire ovrEvt = anyEvt & full;

    always @* begin
        push     = anyEvt & ~full;
        // A break stores a single zero character.
        pushData = brkDet ? {1'b1, 1'b0, 1'b1, 8'h00} : {1'b0, pErr, fErr, shift_q};
    end

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            state_q   <= RX_IDLE;
            tick_q    <= 16'h0000;
            phase_q   <= 4'h0;
            bitCnt_q  <= 4'h0;
            shift_q   <= 8'h00;
            parOk_q   <= 1'b1;
            lowBits_q <= 8'h00;
        end else begin
            state_q <= state_d;
            if (state_q == RX_IDLE || state_q == RX_BRK) begin
                tick_q    <= 16'h0000;
                phase_q   <= 4'h0;
                bitCnt_q  <= 4'h0;
                lowBits_q <= 8'h00;
                parOk_q   <= 1'b1;
            end else begin
                tick_q <= tickEnd ? 16'h0000 : tick_q + 16'h0001;
                if (tickEnd) begin
                    phase_q <= phase_q + 4'h1;
                end
                // Counting low samples lets the stop sample tell a break from a framing error.
                if (midSample) begin
                    lowBits_q <= rxLine ? 8'h00 : lowBits_q + 8'h01;
                end
                if (midSample && state_q == RX_DATA) begin
                    shift_q  <= {rxLine, shift_q[7:1]};
                    bitCnt_q <= bitCnt_q + 4'h1;
                end
                if (midSample && state_q == RX_PAR) begin
                    parOk_q <= (rxLine == expPar);
                end
            end
        end
    end

    // Head flags travel with each character; full FIFO is never written.
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            count_q   <= {(AW+1){1'b0}};
            wrPtr_q   <= {AW{1'b0}};
            rdPtr_q   <= {AW{1'b0}};
            ovrLive_q <= 1'b0;
        end else begin
            if (push) begin
                wrPtr_q <= fifoEn_q ? wrPtr_q + 1'b1 : wrPtr_q;
            end
            if (popRd) begin
                rdPtr_q <= fifoEn_q ? rdPtr_q + 1'b1 : rdPtr_q;
            end
            count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, popRd};
            // Overrun drops once space frees.
            // A pop is what frees an entry, so it ends the overrun indication.
            if (ovrEvt) begin
                ovrLive_q <= 1'b1;
            end else if (popRd) begin
                ovrLive_q <= 1'b0;
            end
        end
    end

    wire statusClr = apbWr && (paddr == `STATUS_OFS);
    wire [4:0] evts = {ovrEvt, brkDet, push & pErr & ~brkDet, push & fErr, push};
    wire [4:0] icWr = (apbWr && paddr == `IRQ_STAT_OFS) ? pwdata[4:0] : 5'h00;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            lineCfg_q   <= 8'h00;
            fifoEn_q    <= 1'b0;
            baudDiv_q   <= `BAUD_DIV_RESET;
            status_q    <= 4'h0;
            irqStat_q   <= 5'h00;
            irqMask_q   <= 5'h00;
            txChar      <= 8'h00;
            txCharValid <= 1'b0;
        end else begin
            txCharValid <= 1'b0;
            if (apbWr && paddr == `DATA_PORT_OFS) begin
                txChar      <= pwdata[7:0];
                txCharValid <= 1'b1;
            end
            if (apbWr && paddr == `LINE_CFG_OFS) begin
                lineCfg_q <= pwdata[7:0];
            end
            if (apbWr && paddr == `CTRL_OFS) begin
                fifoEn_q <= pwdata[`CTRL_FIFO_EN];
            end
            if (apbWr && paddr == `BAUD_DIV_OFS) begin
                baudDiv_q <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
            end
            if (apbWr && paddr == `IRQ_MASK_OFS) begin
                irqMask_q <= pwdata[4:0];
            end
            status_q <= (statusClr ? 4'h0 : status_q) |
                        {ovrEvt, push & pushData[10], push & pushData[9], push & pushData[8]};
            irqStat_q <= (irqStat_q & ~icWr) | evts;
        end
    end

    assign irq = |(irqStat_q & irqMask_q);

    // Status read-only at 0x04; reserved bits zero.
    // Unknown offsets answer with an error response and read as zero.
    always @* begin
        mapped = 1'b1;
        prdata = 32'h00000000;
        case (paddr)
            `DATA_PORT_OFS: prdata = {20'h00000, ovrLive_q, empty ? 11'h000 : headData};
            `STATUS_OFS:    prdata = {28'h0000000, status_q};
            `LINE_CFG_OFS:  prdata = {24'h000000, lineCfg_q};
            `CTRL_OFS:      prdata = {27'h0000000, fifoEn_q, 4'h0};
            `BAUD_DIV_OFS:  prdata = {16'h0000, baudDiv_q};
            `IRQ_MASK_OFS:  prdata = {27'h0000000, irqMask_q};
            `IRQ_STAT_OFS:  prdata = {27'h0000000, irqStat_q};
            default:        mapped = 1'b0;
        endcase
    end
endmodule // uart_rx_data_error_status

//--- core/uart_rx_defs.vh
// Register offsets, field positions, reset values and timing counts for the receive data block.
`ifndef UART_RX_DEFS_VH
`define UART_RX_DEFS_VH
`define DATA_PORT_OFS    8'h00
`define STATUS_OFS       8'h04
`define LINE_CFG_OFS     8'h1c
`define CTRL_OFS         8'h30
`define IRQ_STAT_OFS     8'h3c
`define IRQ_MASK_OFS     8'h38
`define TX_CHAR_OFS      8'h60
`define BAUD_DIV_OFS     8'h24
`define FRAMING_BIT      8
`define PARITY_BIT       9
`define BREAK_BIT        10
`define OVERRUN_BIT      11
`define ST_FRAMING       0
`define ST_PARITY        1
`define ST_BREAK         2
`define ST_OVERRUN       3
`define CFG_PAR_EN       1
`define CFG_PAR_EVEN     2
`define CFG_STICK        7
`define CTRL_FIFO_EN     4
`define BAUD_DIV_RESET   16'h0010
`define OVERSAMPLE       16
`define MID_SAMPLE       8
`define FIFO_DEPTH       16
`define FIFO_AW          4
`endif

//--- core/rx_fifo_mem.v
// Small receive character memory with registered read data.
`timescale 1ns/10ps
module rx_fifo_mem #(
    parameter WIDTH = 12,
    parameter AW    = 4
) (
    input  wire             clk_sys,
    input  wire             wrEn,
    input  wire [AW-1:0]    wrAddr,
    input  wire [WIDTH-1:0] wrData,
    input  wire [AW-1:0]    rdAddr,
    output reg  [WIDTH-1:0] rdData
);
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule // rx_fifo_mem

//--- tb/uart_rx_data_error_status_asserts.sv
// Port-level assertions for the receive data and status block.
`timescale 1ns/10ps
module uart_rx_data_error_status_asserts (
    input wire        clk_sys,
    input wire        rst_b,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        rxLine,
    input wire [7:0]  txChar,
    input wire        txCharValid,
    input wire        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire acc   = psel && penable;
    wire dataW = acc && pwrite && paddr == 8'h00;
    wire dataR = acc && !pwrite && paddr == 8'h00;
    wire statR = acc && !pwrite && paddr == 8'h04;
    wire statW = acc && pwrite && paddr == 8'h04;
    tx_pulse_a: assert property (dataW |=> txCharValid && txChar == $past(pwdata[7:0]))
        else $error("transmit character not queued");
    tx_cause_a: assert property (txCharValid |-> $past(dataW))
        else $error("transmit pulse without a data write");
    tx_once_a: assert property (txCharValid |=> !txCharValid)
        else $error("transmit pulse too long");
    data_resv_a: assert property (dataR |-> prdata[31:12] == 20'h0)
        else $error("data reserved bits not zero");
    stat_resv_a: assert property (statR |-> prdata[31:4] == 28'h0)
        else $error("status reserved bits not zero");
    break_zero_a: assert property (dataR && prdata[10] |-> prdata[7:0] == 8'h00)
        else $error("break character not zero");
    clear_stat_a: assert property (statW ##1 !psel ##1 (psel && !penable) ##1 statR
        |-> prdata[3:0] == 4'h0)
        else $error("status not cleared by write");
    shared_ofs_a: assert property (acc && (paddr == 8'h00 || paddr == 8'h04) |-> !pslverr)
        else $error("error response on mapped offset");
    cover property (dataR && prdata[10]);
    cover property (dataR && prdata[11]);
    cover property ($rose(irq));
endmodule // uart_rx_data_error_status_asserts

//--- tb/serial_tx_model.sv
// Remote serial transmitter driving the receive line.
`timescale 1ns/10ps
module serial_tx_model #(
    parameter BIT_CYC = 16
) (
    input  wire clk_sys,
    output reg  rxLine
);
    initial rxLine = 1'b1;
    task hold(input lvl, input integer n);
        rxLine <= lvl;
        repeat (n) @(posedge clk_sys);
    endtask
    task frame(input [7:0] d, input usePar, input parBit, input stopBit);
        integer k;
        @(posedge clk_sys);
        hold(1'b0, BIT_CYC);
        for (k = 0; k < 8; k = k + 1)
            hold(d[k], BIT_CYC);
        if (usePar)
            hold(parBit, BIT_CYC);
        hold(stopBit, BIT_CYC);
        // Idle time lets the receiver store the character before the next one.
        hold(1'b1, 2 * BIT_CYC);
    endtask
endmodule // serial_tx_model

//--- tb/test_uart_rx_data_error_status.sv
// Self-checking bench for the receive data and status block.
`timescale 1ns/10ps
module test_uart_rx_data_error_status;
    reg         clk_sys = 1'b0;
    reg         rst_b   = 1'b0;
    reg         psel    = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite  = 1'b0;
    reg  [7:0]  paddr   = 8'h00;
    reg  [31:0] pwdata  = 32'h0;
    reg  [31:0] rd;
    reg         err;
    wire [31:0] prdata;
    wire [7:0]  txChar;
    wire        pready, pslverr, rxLine, txCharValid, irq;
    integer     n_fail = 0, tests_run = 0, cyc = 0, i;
    always #5 clk_sys = ~clk_sys;
    uart_rx_data_error_status dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxLine(rxLine), .txChar(txChar),
        .txCharValid(txCharValid), .irq(irq));
    serial_tx_model rem (.clk_sys(clk_sys), .rxLine(rxLine));
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            summarize;
        end
    end
    task chk(input [31:0] got, input [31:0] exp, input string what);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input [7:0] a, input [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask
    task t_regs;
        rdc(8'h00, 32'h0, "data reset");
        rdc(8'h04, 32'h0, "status reset");
        rdc(8'h24, 32'h10, "divisor reset");
        apb(1'b0, 8'h08, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b1, 8'h24, 32'h1);
        apb(1'b1, 8'h00, 32'h1a5);
        @(posedge clk_sys);
        chk({txCharValid, txChar}, 32'h1a5, "transmit char");
        $display("t_regs done");
    endtask
    task t_frame;
        apb(1'b1, 8'h38, 32'h0);
        rem.frame(8'h5a, 1'b0, 1'b0, 1'b1);
        rdc(8'h3c, 32'h1, "char event");
        chk({31'h0, irq}, 32'h0, "masked irq");
        apb(1'b1, 8'h38, 32'h1);
        @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1, "unmasked irq");
        apb(1'b1, 8'h3c, 32'h1);
        @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0, "cleared irq");
        rdc(8'h00, 32'h5a, "good char");
        rem.frame(8'hc3, 1'b0, 1'b0, 1'b0);
        rdc(8'h00, 32'h1c3, "framing char");
        rdc(8'h04, 32'h1, "framing status");
        apb(1'b1, 8'h04, 32'hffffffff);
        rdc(8'h04, 32'h0, "status clear");
        $display("t_frame done");
    endtask
    task par_case(input [7:0] cfg, input pb, input [31:0] exp);
        apb(1'b1, 8'h1c, {24'h0, cfg});
        rem.frame(8'h5a, 1'b1, pb, 1'b1);
        rdc(8'h00, exp, "parity char");
        rdc(8'h04, {30'h0, exp[9], 1'b0}, "parity status");
        apb(1'b1, 8'h04, 32'h0);
    endtask
    task t_parity;
        par_case(8'h06, 1'b1, 32'h25a);
        par_case(8'h02, 1'b1, 32'h05a);
        par_case(8'h86, 1'b0, 32'h05a);
        par_case(8'h82, 1'b0, 32'h25a);
        apb(1'b1, 8'h1c, 32'h0);
        $display("t_parity done");
    endtask
    task t_break;
        rem.hold(1'b0, 640);
        rem.hold(1'b1, 32);
        rdc(8'h00, 32'h500, "break char");
        rdc(8'h00, 32'h0, "single break char");
        rdc(8'h04, 32'h5, "break status");
        apb(1'b1, 8'h04, 32'h0);
        rem.frame(8'h3c, 1'b0, 1'b0, 1'b1);
        rdc(8'h00, 32'h3c, "char after break");
        $display("t_break done");
    endtask
    task t_fifo;
        apb(1'b1, 8'h30, 32'h10);
        for (i = 0; i < 17; i = i + 1)
            rem.frame(8'h30 + i[7:0], 1'b0, 1'b0, i != 3);
        rdc(8'h04, 32'h9, "overrun status");
        for (i = 0; i < 16; i = i + 1)
            rdc(8'h00, 32'h30 + i + (i == 3 ? 32'h100 : 32'h0) + (i == 0 ? 32'h800 : 32'h0),
                "fifo char");
        rdc(8'h00, 32'h0, "lost char");
        $display("t_fifo done");
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_regs;
        t_frame;
        t_parity;
        t_break;
        t_fifo;
        summarize;
    end
endmodule // test_uart_rx_data_error_status
bind uart_rx_data_error_status uart_rx_data_error_status_asserts chk_i (.clk_sys(clk_sys),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxLine(rxLine),
    .txChar(txChar), .txCharValid(txCharValid), .irq(irq));
